/* File: rtl/ccec_map.svh */
// Register offsets, field positions, reset values and timing counts of the charger control
`ifndef CCEC_MAP_SVH
`define CCEC_MAP_SVH

// Register offsets
`define CCEC_ADDR_TIMERS     8'h8A
`define CCEC_ADDR_TERM       8'h8D
`define CCEC_ADDR_VREG       8'h8F

// Reset values
`define CCEC_RST_TIMERS      8'h0A
`define CCEC_RST_TERM        8'h41
`define CCEC_RST_VREG        8'h2B

// Writable bits of the timer register, reserved bit reads zero
`define CCEC_TIMERS_WMASK    8'hBF

// Timer register fields
`define CCEC_TMR_PRE_BIT     7
`define CCEC_TMR_EOC_LSB     3
`define CCEC_TMR_FC_LSB      0

// Termination register fields
`define CCEC_TERM_MODE_BIT   7
`define CCEC_TERM_ICODE_LSB  4
`define CCEC_TERM_EXIT_BIT   3
`define CCEC_TERM_ISO_BIT    2
`define CCEC_TERM_RST_LSB    0

// Voltage register fields
`define CCEC_VREG_CV_LSB     0
`define CCEC_VREG_SMIN_LSB   6

// Charge voltage decode
`define CCEC_CV_BASE_MV      13'h0DAC
`define CCEC_CV_STEP_MV      13'h0014
`define CCEC_CV_FLOOR_CODE   6'h08
`define CCEC_CV_CEIL_CODE    6'h37
`define CCEC_CV_MAX_MV       13'h1158

// Termination current decode, mA
`define CCEC_ITERM_0         6'h05
`define CCEC_ITERM_1         6'h0A
`define CCEC_ITERM_2         6'h14
`define CCEC_ITERM_3         6'h1E
`define CCEC_ITERM_4         6'h32

// Clock and time base
`define CCEC_CLK_MHZ         200
`define CCEC_TICK_US         1000
`define CCEC_TICK_CYCLES     (`CCEC_TICK_US * `CCEC_CLK_MHZ)
`define CCEC_HOUR_MS         3600000
`define CCEC_MIN_MS          60000
`define CCEC_FC_STEP_H       2
`define CCEC_EOC_STEP_MIN    10
`define CCEC_EOC_DB0_S       16
`define CCEC_EOC_DB0_MS      (`CCEC_EOC_DB0_S * 1000)
`define CCEC_CUR_DB_MS       16
`define CCEC_TOPOFF_DB_MS    16

// State sense codes
`define CCEC_SNS_OFF         8'h08
`define CCEC_SNS_CC          8'h01
`define CCEC_SNS_CV          8'h02
`define CCEC_SNS_EOC         8'h03
`define CCEC_SNS_DONE        8'h04
`define CCEC_SNS_TFAULT      8'h06
`define CCEC_SNS_WDOG        8'h0B

`endif

/* File: rtl/ccec_pkg.sv */
// Types of the charger voltage, timer and end-of-charge control
package ccec_pkg;
  typedef enum logic [2:0] {
    CCEC_OFF,
    CCEC_FAST_CC,
    CCEC_FAST_CV,
    CCEC_TOPOFF,
    CCEC_DONE,
    CCEC_TFAULT,
    CCEC_WDOG_SUSP
  } ccec_state_e;

  typedef logic [26:0] ccec_ms_t;
endpackage

/* File: rtl/ccec_tick_gen.sv */
// Prescaler giving a one-cycle time-base enable pulse
`timescale 1ns/10ps
`default_nettype none
module ccec_tick_gen #(
  parameter int unsigned DIV = 200000
) (
  input  wire logic core_clk, // System clock
  input  wire logic srst,     // Synchronous reset, active high
  output logic      tick      // One-cycle pulse every DIV cycles
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [W-1:0] LAST = W'(DIV - 1);

  logic [W-1:0] cnt_r;
  logic [W-1:0] cnt_nxt;

  // Wrap at the last count
  always_comb begin
    if (cnt_r == LAST) begin
      cnt_nxt = '0;
    end else begin
      cnt_nxt = cnt_r + W'(1);
    end
  end

  // Counter register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign tick = (cnt_r == LAST);
endmodule
`default_nettype wire

/* File: rtl/ccec_charger_ctrl.sv */
// Charger voltage setpoint, fast-charge timer and end-of-charge control
`timescale 1ns/10ps
`default_nettype none
`include "ccec_map.svh"
module ccec_charger_ctrl #(
  parameter int unsigned TICK_CYCLES   = `CCEC_TICK_CYCLES,  // Cycles per 1 ms tick
  parameter int unsigned CUR_DB_MS     = `CCEC_CUR_DB_MS,    // Current debounce, ms
  parameter int unsigned TOPOFF_DB_MS  = `CCEC_TOPOFF_DB_MS, // Top-off debounce, ms
  parameter int unsigned HOUR_MS       = `CCEC_HOUR_MS,      // Length of an hour, ms
  parameter int unsigned MIN_MS        = `CCEC_MIN_MS        // Length of a minute, ms
) (
  input  wire logic         core_clk,            // System clock, 200 MHz
  input  wire logic         srst,                // Synchronous reset, active high
  input  wire logic [7:0]   reg_addr,            // Register address
  input  wire logic         reg_wr,              // Write strobe
  input  wire logic [7:0]   reg_wdata,           // Write data
  input  wire logic         reg_rd,              // Read strobe
  output logic      [7:0]   reg_rdata,           // Read data, registered
  input  wire logic         charge_enable,       // Charging requested by operation select
  input  wire logic         vbat_at_reg,         // Battery reached regulation voltage
  input  wire logic         cur_below_term,      // Charge current below termination level
  input  wire logic         vbat_below_restart,  // Battery below regulation minus restart
  input  wire logic         wdog_expired,        // Watchdog not serviced
  input  wire logic         in_current_limit,    // Input in current limit
  input  wire logic         in_voltage_low,      // Input voltage low
  input  wire logic         sys_load_demand,     // System load drawing adapter current
  output ccec_pkg::ccec_state_e chg_state,       // Charger state
  output logic      [12:0]  vreg_mv,             // Regulation voltage, mV
  output logic              vreg_active,         // Voltage loop holding setpoint
  output logic      [5:0]   iterm_ma,            // Termination current, mA
  output logic              iterm_reserved,      // Reserved termination code
  output logic              charge_reduce,       // Throttle charge current
  output logic              charger_good_flag,   // Charger good
  output logic      [7:0]   charger_state_sense, // State sense code
  output logic              chg_irq,             // One-cycle event pulse
  output logic              precharge_timeout,   // Precharge timeout field
  output logic              termination_mode,    // Termination mode field
  output logic              exit_control,        // Top-off exit control field
  output logic              forced_battery_isolation, // Forced isolation field
  output logic      [1:0]   restart_setting      // Restart setting field
);
  import ccec_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [7:0] timers_r, timers_nxt;
  logic [7:0] term_r, term_nxt;
  logic [7:0] vreg_r, vreg_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Register writes and reads
  always_comb begin
    timers_nxt = timers_r;
    term_nxt   = term_r;
    vreg_nxt   = vreg_r;
    rdata_nxt  = rdata_r;
    if (reg_wr) begin
      case (reg_addr)
        `CCEC_ADDR_TIMERS: timers_nxt = reg_wdata & `CCEC_TIMERS_WMASK;
        `CCEC_ADDR_TERM:   term_nxt   = reg_wdata;
        `CCEC_ADDR_VREG:   vreg_nxt   = reg_wdata;
        default:           ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        `CCEC_ADDR_TIMERS: rdata_nxt = timers_r;
        `CCEC_ADDR_TERM:   rdata_nxt = term_r;
        `CCEC_ADDR_VREG:   rdata_nxt = vreg_r;
        default:           rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      timers_r <= `CCEC_RST_TIMERS;
      term_r   <= `CCEC_RST_TERM;
      vreg_r   <= `CCEC_RST_VREG;
      rdata_r  <= 8'h00;
    end else begin
      timers_r <= timers_nxt;
      term_r   <= term_nxt;
      vreg_r   <= vreg_nxt;
      rdata_r  <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

  // Field extraction
  logic [5:0] cv_code;
  logic [2:0] fc_code;
  logic [2:0] eoc_code;
  logic [2:0] iterm_code;
  assign cv_code    = vreg_r[`CCEC_VREG_CV_LSB +: 6];
  assign fc_code    = timers_r[`CCEC_TMR_FC_LSB +: 3];
  assign eoc_code   = timers_r[`CCEC_TMR_EOC_LSB +: 3];
  assign iterm_code = term_r[`CCEC_TERM_ICODE_LSB +: 3];
  assign precharge_timeout        = timers_r[`CCEC_TMR_PRE_BIT];
  assign termination_mode         = term_r[`CCEC_TERM_MODE_BIT];
  assign exit_control             = term_r[`CCEC_TERM_EXIT_BIT];
  assign forced_battery_isolation = term_r[`CCEC_TERM_ISO_BIT];
  assign restart_setting          = term_r[`CCEC_TERM_RST_LSB +: 2];

  ////////////////////////////////////////////////////////////////////////////
  // Setpoint decode
  logic [12:0] vreg_mv_nxt, vreg_mv_r;
  logic [5:0]  iterm_nxt, iterm_r;

  // Voltage and termination current tables
  always_comb begin
    if (cv_code <= `CCEC_CV_FLOOR_CODE) begin
      vreg_mv_nxt = `CCEC_CV_BASE_MV;
    end else if (cv_code >= `CCEC_CV_CEIL_CODE) begin
      vreg_mv_nxt = `CCEC_CV_MAX_MV;
    end else begin
      vreg_mv_nxt = `CCEC_CV_BASE_MV
                  + 13'(13'(cv_code - `CCEC_CV_FLOOR_CODE) * `CCEC_CV_STEP_MV);
    end
    case (iterm_code)
      3'h0:    iterm_nxt = `CCEC_ITERM_0;
      3'h1:    iterm_nxt = `CCEC_ITERM_1;
      3'h2:    iterm_nxt = `CCEC_ITERM_2;
      3'h3:    iterm_nxt = `CCEC_ITERM_3;
      default: iterm_nxt = `CCEC_ITERM_4;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      vreg_mv_r <= `CCEC_CV_BASE_MV;
      iterm_r   <= `CCEC_ITERM_0;
    end else begin
      vreg_mv_r <= vreg_mv_nxt;
      iterm_r   <= iterm_nxt;
    end
  end

  assign vreg_mv        = vreg_mv_r;
  assign iterm_ma       = iterm_r;
  assign iterm_reserved = (iterm_code > 3'h4);

  ////////////////////////////////////////////////////////////////////////////
  // Time base
  logic tick;

  ccec_tick_gen #(
    .DIV (TICK_CYCLES)
  ) u_tick (
    .core_clk (core_clk),
    .srst     (srst),
    .tick     (tick)
  );

  // Limits in ms
  ccec_ms_t fc_limit_ms, eoc_limit_ms, notify_ms, db_ms;
  assign fc_limit_ms  = 27'(fc_code) * 27'(`CCEC_FC_STEP_H * HOUR_MS);
  assign eoc_limit_ms = (eoc_code == 3'h0) ? 27'(`CCEC_EOC_DB0_MS)
                      : 27'(eoc_code) * 27'(`CCEC_EOC_STEP_MIN * MIN_MS);
  assign notify_ms    = 27'(CUR_DB_MS + TOPOFF_DB_MS);
  assign db_ms        = 27'(CUR_DB_MS);

  ////////////////////////////////////////////////////////////////////////////
  // Charger state machine and timers
  ccec_state_e state_r, state_nxt;
  ccec_ms_t    fc_cnt_r, fc_cnt_nxt;
  ccec_ms_t    dwell_r, dwell_nxt;
  ccec_ms_t    db_cnt_r, db_cnt_nxt;
  logic        good_r, good_nxt;
  logic        notified_r, notified_nxt;
  logic        irq_r, irq_nxt;
  logic [7:0]  sense_r, sense_nxt;
  logic        reduce_r, reduce_nxt;
  logic        fast, fc_fault;

  assign fast     = (state_r == CCEC_FAST_CC) || (state_r == CCEC_FAST_CV);
  assign fc_fault = (fc_code != 3'h0) && (fc_cnt_r >= fc_limit_ms);

  // Next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      CCEC_OFF: begin
        if (charge_enable) begin
          state_nxt = CCEC_FAST_CC;
        end
      end
      CCEC_FAST_CC: begin
        if (fc_fault) begin
          state_nxt = CCEC_TFAULT;
        end else if (vbat_at_reg) begin
          state_nxt = CCEC_FAST_CV;
        end
      end
      CCEC_FAST_CV: begin
        if (wdog_expired) begin
          state_nxt = CCEC_WDOG_SUSP;
        end else if (fc_fault) begin
          state_nxt = CCEC_TFAULT;
        end else if (cur_below_term && (db_cnt_r >= db_ms)) begin
          state_nxt = CCEC_TOPOFF;
        end
      end
      CCEC_TOPOFF: begin
        if (wdog_expired) begin
          state_nxt = CCEC_WDOG_SUSP;
        end else if (vbat_below_restart) begin
          state_nxt = CCEC_FAST_CC;
        end else if (dwell_r >= eoc_limit_ms) begin
          state_nxt = CCEC_DONE;
        end
      end
      CCEC_DONE: begin
        if (wdog_expired) begin
          state_nxt = CCEC_WDOG_SUSP;
        end else if (vbat_below_restart) begin
          state_nxt = CCEC_FAST_CC;
        end
      end
      CCEC_TFAULT, CCEC_WDOG_SUSP: state_nxt = state_r;
      default: state_nxt = CCEC_OFF;
    endcase
    if (!charge_enable) begin
      state_nxt = CCEC_OFF;
    end
  end

  // Timers, flags and outputs
  always_comb begin
    fc_cnt_nxt   = fc_cnt_r;
    dwell_nxt    = dwell_r;
    db_cnt_nxt   = db_cnt_r;
    good_nxt     = good_r;
    notified_nxt = notified_r;
    irq_nxt      = 1'b0;
    sense_nxt    = sense_r;
    // Fast timer spans CC and CV, cleared on entry from outside
    if (!fast) begin
      fc_cnt_nxt = '0;
    end else if (tick && (fc_cnt_r != '1)) begin
      fc_cnt_nxt = fc_cnt_r + 27'(1);
    end
    // Dwell timer cleared on every state change
    if (state_nxt != state_r) begin
      dwell_nxt = '0;
    end else if (tick && (dwell_r != '1)) begin
      dwell_nxt = dwell_r + 27'(1);
    end
    // Low-current debounce in CV only
    if ((state_r != CCEC_FAST_CV) || !cur_below_term) begin
      db_cnt_nxt = '0;
    end else if (tick && (db_cnt_r != '1)) begin
      db_cnt_nxt = db_cnt_r + 27'(1);
    end
    // One notification per top-off visit
    if (state_r != CCEC_TOPOFF) begin
      notified_nxt = 1'b0;
      good_nxt     = 1'b0;
    end else if (!notified_r && (dwell_r >= notify_ms)) begin
      notified_nxt = 1'b1;
      good_nxt     = 1'b1;
      irq_nxt      = 1'b1;
    end
    case (state_r)
      CCEC_OFF:       sense_nxt = `CCEC_SNS_OFF;
      CCEC_FAST_CC:   sense_nxt = `CCEC_SNS_CC;
      CCEC_FAST_CV:   sense_nxt = `CCEC_SNS_CV;
      CCEC_TOPOFF:    sense_nxt = notified_nxt ? `CCEC_SNS_EOC : sense_r;
      CCEC_DONE:      sense_nxt = `CCEC_SNS_DONE;
      CCEC_TFAULT:    sense_nxt = `CCEC_SNS_TFAULT;
      CCEC_WDOG_SUSP: sense_nxt = `CCEC_SNS_WDOG;
      default:        sense_nxt = `CCEC_SNS_OFF;
    endcase
    reduce_nxt = in_current_limit || in_voltage_low || sys_load_demand;
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_r    <= CCEC_OFF;
      fc_cnt_r   <= '0;
      dwell_r    <= '0;
      db_cnt_r   <= '0;
      good_r     <= 1'b0;
      notified_r <= 1'b0;
      irq_r      <= 1'b0;
      sense_r    <= `CCEC_SNS_OFF;
      reduce_r   <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      fc_cnt_r   <= fc_cnt_nxt;
      dwell_r    <= dwell_nxt;
      db_cnt_r   <= db_cnt_nxt;
      good_r     <= good_nxt;
      notified_r <= notified_nxt;
      irq_r      <= irq_nxt;
      sense_r    <= sense_nxt;
      reduce_r   <= reduce_nxt;
    end
  end

  assign chg_state           = state_r;
  assign charger_good_flag   = good_r;
  assign charger_state_sense = sense_r;
  assign chg_irq             = irq_r;
  assign charge_reduce       = reduce_r && (state_r != CCEC_OFF);
  // Voltage loop held in CV and top-off alike
  assign vreg_active = (state_r == CCEC_FAST_CV) || (state_r == CCEC_TOPOFF);
endmodule
`default_nettype wire

/* File: verification/ccec_charger_ctrl_asserts.sv */
// Port-level assertions of the charger control block
`timescale 1ns/10ps
`default_nettype none
module ccec_charger_ctrl_asserts (
  input  wire logic        core_clk,            // Clock
  input  wire logic        srst,                // Sync reset
  input  wire logic [7:0]  reg_addr,            // Address
  input  wire logic        reg_wr,              // Write strobe
  input  wire logic [7:0]  reg_wdata,           // Write data
  input  wire logic        cur_below_term,      // Low current
  input  wire logic        vbat_below_restart,  // Restart level
  input  wire logic        wdog_expired,        // Watchdog lapse
  input  wire logic        charge_enable,       // Charge request
  input  wire logic        in_current_limit,    // Input limit
  input  wire logic        in_voltage_low,      // Input low
  input  wire logic        sys_load_demand,     // System load
  input  var  ccec_pkg::ccec_state_e chg_state, // State
  input  wire logic [12:0] vreg_mv,             // Setpoint
  input  wire logic        vreg_active,         // Voltage loop on
  input  wire logic        iterm_reserved,      // Reserved code
  input  wire logic        charge_reduce,       // Throttle
  input  wire logic        charger_good_flag,   // Good flag
  input  wire logic [7:0]  charger_state_sense, // Sense code
  input  wire logic        chg_irq,             // Event pulse
  input  wire logic        termination_mode,    // Mode field
  input  wire logic [1:0]  restart_setting      // Restart field
);
  import ccec_pkg::*;
  logic any_reduce;

  // Any cause of throttling
  assign any_reduce = in_current_limit | in_voltage_low | sys_load_demand;

  // Setpoint expected for a voltage code
  function automatic logic [12:0] cv_mv(input logic [5:0] c);
    if (c <= 6'h08) return 13'h0DAC;
    if (c >= 6'h37) return 13'h1158;
    return 13'h0DAC + 13'(c - 6'h08) * 13'h0014;
  endfunction

  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);

  // Report that accompanies the top-off event
  sequence good_report;
    charger_good_flag && charger_state_sense == 8'h03;
  endsequence
  sequence stay_topoff;
    chg_state == CCEC_TOPOFF ##1 chg_state == CCEC_TOPOFF;
  endsequence

  topoff_entry_a: assert property ((chg_state == CCEC_TOPOFF && $past(chg_state) != CCEC_TOPOFF)
    |-> $past(chg_state) == CCEC_FAST_CV && $past(cur_below_term)) else $error("bad top-off entry");
  irq_report_a: assert property ($rose(chg_irq) |-> good_report ##1 !chg_irq)
    else $error("event without report");
  topoff_reg_a: assert property (chg_state == CCEC_TOPOFF |-> vreg_active)
    else $error("voltage loop off in top-off");
  throttle_follow_a: assert property (stay_topoff |-> charge_reduce == $past(any_reduce))
    else $error("throttle mismatch");
  done_entry_a: assert property ((chg_state == CCEC_DONE && $past(chg_state) != CCEC_DONE)
    |-> $past(chg_state) == CCEC_TOPOFF) else $error("done not from top-off");
  restart_cc_a: assert property ((chg_state == CCEC_TOPOFF && vbat_below_restart
    && !wdog_expired && charge_enable) |=> chg_state == CCEC_FAST_CC) else $error("no restart");
  wdog_susp_a: assert property ((chg_state == CCEC_TOPOFF && wdog_expired && charge_enable)
    |=> chg_state == CCEC_WDOG_SUSP) else $error("no watchdog suspend");
  iterm_res_a: assert property ((reg_wr && reg_addr == 8'h8D)
    |=> iterm_reserved == ($past(reg_wdata[6:4]) > 3'h4)) else $error("reserved flag wrong");
  term_field_a: assert property ((reg_wr && reg_addr == 8'h8D) |=> termination_mode ==
    $past(reg_wdata[7]) && restart_setting == $past(reg_wdata[1:0])) else $error("field wrong");
  vreg_code_a: assert property ((reg_wr && reg_addr == 8'h8F)
    |-> ##2 vreg_mv == cv_mv($past(reg_wdata[5:0], 2))) else $error("setpoint wrong");
endmodule

bind ccec_charger_ctrl ccec_charger_ctrl_asserts u_ccec_chk (
  .core_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .cur_below_term, .vbat_below_restart,
  .wdog_expired, .charge_enable, .in_current_limit, .in_voltage_low, .sys_load_demand,
  .chg_state, .vreg_mv, .vreg_active, .iterm_reserved, .charge_reduce, .charger_good_flag,
  .charger_state_sense, .chg_irq, .termination_mode, .restart_setting
);
`default_nettype wire

/* File: verification/ccec_host_model.sv */
// Host model driving register strobes and the charge request
`timescale 1ns/10ps
`default_nettype none
module ccec_host_model (
  input  wire logic       core_clk,      // Clock
  input  wire logic [7:0] reg_rdata,     // Read data
  output logic      [7:0] reg_addr,      // Address
  output logic      [7:0] reg_wdata,     // Write data
  output logic            reg_wr,        // Write strobe
  output logic            reg_rd,        // Read strobe
  output logic            charge_enable  // Charge request
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    charge_enable = 1'b0;
  end

  // One access, bus scrambled once released
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] v,
                      output logic [7:0] q);
    @(negedge core_clk);
    reg_addr = a;
    reg_wdata = v;
    reg_wr = w;
    reg_rd = ~w;
    @(negedge core_clk);
    q = reg_rdata;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~v;
  endtask

  // Raise or drop the charge request at the next falling edge
  task automatic set_chg(input logic v);
    @(negedge core_clk);
    charge_enable = v;
  endtask
endmodule
`default_nettype wire

/* File: verification/charger_cv_eoc_control_tb.sv */
// Self-checking bench of the charger control block
`timescale 1ns/10ps
`default_nettype none
module charger_cv_eoc_control_tb;
  import ccec_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        vbat_at_reg = 1'b0;
  logic        cur_below_term = 1'b0;
  logic        vbat_below_restart = 1'b0;
  logic        wdog_expired = 1'b0;
  logic        in_current_limit = 1'b0;
  logic        in_voltage_low = 1'b0;
  logic        sys_load_demand = 1'b0;
  logic        precharge_timeout, termination_mode, exit_control, forced_battery_isolation;
  logic [1:0]  restart_setting;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata, sense, q, d;
  logic        reg_wr, reg_rd, charge_enable, vreg_active, iterm_res, reduce, good, irq;
  logic [12:0] vreg_mv;
  logic [5:0]  iterm_ma;
  wire  [5:0]  fields;
  ccec_state_e st;
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;
  int          n, t0;
  int          seed = 32'h6D342D59;

  // Field outputs gathered for compact compares
  assign fields = {precharge_timeout, termination_mode, exit_control, forced_battery_isolation,
                   restart_setting};

  ccec_charger_ctrl #(.TICK_CYCLES(2), .HOUR_MS(20), .MIN_MS(5)) dut (
    .core_clk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .charge_enable,
    .vbat_at_reg, .cur_below_term, .vbat_below_restart, .wdog_expired,
    .in_current_limit, .in_voltage_low, .sys_load_demand,
    .chg_state(st), .vreg_mv, .vreg_active, .iterm_ma, .iterm_reserved(iterm_res),
    .charge_reduce(reduce), .charger_good_flag(good), .charger_state_sense(sense),
    .chg_irq(irq), .precharge_timeout, .termination_mode, .exit_control,
    .forced_battery_isolation, .restart_setting);
  ccec_host_model host (.core_clk, .reg_rdata, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .charge_enable);

  // Clock and hang guard
  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count = err_count + 1;
      results();
    end
  end

  // Expected setpoint and termination current
  function automatic logic [12:0] cv_exp(input logic [5:0] c);
    if (c <= 6'h08) return 13'h0DAC;
    if (c >= 6'h37) return 13'h1158;
    return 13'h0DAC + 13'(c - 6'h08) * 13'h0014;
  endfunction
  function automatic logic [5:0] it_exp(input logic [2:0] t);
    case (t)
      3'h0: return 6'h05;
      3'h1: return 6'h0A;
      3'h2: return 6'h14;
      3'h3: return 6'h1E;
      default: return 6'h32;
    endcase
  endfunction

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  // Bounded wait for a state, then confirm it
  task automatic wait_st(input ccec_state_e s, input int lim);
    n = 0;
    while (st !== s && n < lim) begin
      @(negedge core_clk);
      n = n + 1;
    end
    check(st, s);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (4) @(negedge core_clk);
    srst = 1'b0;
    // Reset values, reserved bit, unmapped read
    host.xfer(1'b0, 8'h8A, 8'h00, q);
    check(q, 8'h0A);
    host.xfer(1'b0, 8'h8D, 8'h00, q);
    check(q, 8'h41);
    d = 8'($random(seed));
    host.xfer(1'b0, d & 8'h7F, 8'h00, q);
    check(q, 8'h00);
    check(vreg_mv, 13'h1068);
    check(iterm_ma, it_exp(3'h4));
    host.xfer(1'b1, 8'h8A, 8'hFF, q);
    host.xfer(1'b0, 8'h8A, 8'h00, q);
    check(q, 8'hBF);
    check(fields[5], 1'b1);
    $display("test registers done");
    // Every voltage code with random upper bits
    for (int c = 0; c < 64; c++) begin
      d = 8'($random(seed));
      host.xfer(1'b1, 8'h8F, {d[7:6], 6'(c)}, q);
      @(negedge core_clk);
      check(vreg_mv, cv_exp(6'(c)));
    end
    // Every termination code with random other fields
    for (int t = 0; t < 8; t++) begin
      d = 8'($random(seed));
      d[6:4] = 3'(t);
      host.xfer(1'b1, 8'h8D, d, q);
      @(negedge core_clk);
      check(iterm_ma, it_exp(3'(t)));
      check(iterm_res, t > 4);
      check(fields[4:0], {d[7], d[3:0]});
    end
    host.xfer(1'b1, 8'h8F, 8'h2B, q);
    host.xfer(1'b1, 8'h8A, 8'h08, q);
    $display("test decode done");
    // Charge into top-off, event, throttle, done
    host.set_chg(1'b1);
    wait_st(CCEC_FAST_CC, 4);
    vbat_at_reg = 1'b1;
    cur_below_term = 1'b1;
    wait_st(CCEC_TOPOFF, 40);
    t0 = cyc;
    n = 0;
    while (irq !== 1'b1 && n < 80) begin
      @(negedge core_clk);
      n = n + 1;
    end
    check({irq, good, sense}, {2'b11, 8'h03});
    check({vreg_active, vreg_mv}, {1'b1, 13'h1068});
    for (int i = 0; i < 6; i++) begin
      d = 8'($random(seed));
      {sys_load_demand, in_voltage_low, in_current_limit} = d[2:0];
      @(negedge core_clk);
      check(reduce, |d[2:0]);
    end
    {sys_load_demand, in_voltage_low, in_current_limit} = 3'h0;
    wait_st(CCEC_DONE, 120);
    check((cyc - t0) inside {[97:106]}, 1'b1);
    $display("test top-off done");
    // Restart from done, restart from top-off, watchdog in top-off
    vbat_below_restart = 1'b1;
    wait_st(CCEC_FAST_CC, 4);
    vbat_below_restart = 1'b0;
    wait_st(CCEC_TOPOFF, 40);
    vbat_below_restart = 1'b1;
    @(negedge core_clk);
    check(st, CCEC_FAST_CC);
    vbat_below_restart = 1'b0;
    wait_st(CCEC_TOPOFF, 40);
    wdog_expired = 1'b1;
    @(negedge core_clk);
    check(st, CCEC_WDOG_SUSP);
    host.set_chg(1'b0);
    wdog_expired = 1'b0;
    $display("test exits done");
    // Fast timer fault at 2 h, then host restart
    host.xfer(1'b1, 8'h8A, 8'h09, q);
    vbat_at_reg = 1'b0;
    host.set_chg(1'b1);
    t0 = cyc;
    wait_st(CCEC_TFAULT, 100);
    check((cyc - t0) inside {[76:86]}, 1'b1);
    host.set_chg(1'b0);
    host.set_chg(1'b1);
    wait_st(CCEC_FAST_CC, 4);
    $display("test timer fault done");
    results();
  end
endmodule
`default_nettype wire
